// >>> hw/apcf_top.sv
// Pin strap decode, input mux select, code range and static power control.
// Output codes are limited per captured format and gain setting.
// acq_start and raw_valid are one-cycle pulses on core_clk.
// Assumes strap pins are asynchronous to core_clk; floating pins arrive as
// a separate "pin is floating" indication from the pad sensing logic.
`timescale 1ns/1ps
`default_nettype none

module apcf_top
(
    // Clock and reset
    input  wire logic                               core_clk,
    input  wire logic                               rst,
    // Strap pins
    input  wire logic                               input_pick_bit2,
    input  wire logic                               input_pick_bit1,
    input  wire logic                               input_pick_bit0,
    input  wire logic                               amp_gain_msb_or_bypass,
    input  wire logic                               amp_gain_msb_floating,
    input  wire logic                               amp_gain_bit1,
    input  wire logic                               amp_gain_bit0,
    input  wire logic                               format_strap_floating,
    input  wire logic                               economy_mode_sel,
    input  wire logic                               sweep_mode_sel,
    // Power control pins
    input  wire logic                               chip_select_n,
    input  wire logic                               sleep_request_n,
    // Conversion path
    input  wire logic                               acq_start,
    input  wire logic                               raw_valid,
    input  wire logic signed [apcf_pkg::CODE_W-1:0] raw_code,
    output logic [apcf_pkg::NUM_INPUTS-1:0]         input_route,
    output apcf_pkg::apcf_cfg_type                  active_cfg,
    output logic [4:0]                              amp_gain,
    output logic                                    code_valid,
    output logic [apcf_pkg::CODE_W-1:0]             code_out,
    // Power state
    output logic                                    static_sleep
);
    import apcf_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int unsigned NPIN = 12;
    // Power pins are active low: reset them to their idle level so that
    // leaving reset cannot look like a sleep request
    localparam logic [NPIN-1:0] PIN_IDLE = 12'hc00;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_sync;
    logic [NPIN-1:0] next_pin_meta;
    logic [NPIN-1:0] next_pin_sync;

    // Bit order: picks 0..2, gain 3..6, format 7, economy 8,
    // sweep 9, chip select 10, sleep request 11
    assign pin_raw = {sleep_request_n, chip_select_n, sweep_mode_sel,
                      economy_mode_sel, format_strap_floating,
                      amp_gain_bit0, amp_gain_bit1, amp_gain_msb_floating,
                      amp_gain_msb_or_bypass, input_pick_bit0,
                      input_pick_bit1, input_pick_bit2};

    always_comb begin
        next_pin_meta = pin_raw;
        next_pin_sync = pin_meta;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
        end else begin
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
        end
    end

    // ------------------------------------------------------------
    // Strap decode
    // ------------------------------------------------------------
    apcf_cfg_type pin_cfg;
    logic         cs_n_s;
    logic         pd_n_s;

    always_comb begin
        pin_cfg            = '0;
        pin_cfg.pick       = {pin_sync[0], pin_sync[1], pin_sync[2]};
        pin_cfg.bypass     = pin_sync[4];
        pin_cfg.gain_lo    = {pin_sync[5], pin_sync[6]};
        pin_cfg.gain_bits  = {pin_sync[3], pin_sync[5], pin_sync[6]};
        pin_cfg.signed_fmt = pin_sync[7];
        pin_cfg.economy    = pin_sync[8];
        pin_cfg.sweep      = pin_sync[9];
    end

    assign cs_n_s = pin_sync[10];
    assign pd_n_s = pin_sync[11];

    // ------------------------------------------------------------
    // Per-acquisition capture and sweep sequencer
    // ------------------------------------------------------------
    apcf_cfg_type          cfg;
    apcf_cfg_type          next_cfg;
    logic [SEL_W-1:0]      sweep_ch;
    logic [SEL_W-1:0]      next_sweep_ch;
    logic                  econ_acq_done;
    logic                  next_econ_acq_done;

    always_comb begin
        next_cfg           = cfg;
        next_sweep_ch      = sweep_ch;
        next_econ_acq_done = econ_acq_done;
        if (acq_start) begin
            next_cfg = pin_cfg;
            if (pin_cfg.sweep) begin
                next_cfg.pick = sweep_ch;
                next_sweep_ch = sweep_ch + 3'h1;
            end else begin
                // Sweep restarts at input 0 once sweep is off
                next_sweep_ch = FIRST_INPUT;
            end
            if (pin_cfg.economy) begin
                next_econ_acq_done = 1'b1;
            end
        end
        if (!pin_cfg.economy) begin
            next_econ_acq_done = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg           <= '0;
            sweep_ch      <= FIRST_INPUT;
            econ_acq_done <= 1'b0;
        end else begin
            cfg           <= next_cfg;
            sweep_ch      <= next_sweep_ch;
            econ_acq_done <= next_econ_acq_done;
        end
    end

    assign active_cfg = cfg;

    // ------------------------------------------------------------
    // Registered mux select and gain decode
    // ------------------------------------------------------------
    localparam logic [4:0] GAIN_UNITY = 5'h01;
    logic [NUM_INPUTS-1:0] route;
    logic [NUM_INPUTS-1:0] next_route;
    logic [4:0]            gain;
    logic [4:0]            next_gain;

    // One compare per input: a single pick value matches only one
    for (genvar ch = 0; ch < NUM_INPUTS; ch = ch + 1) begin : g_route
        assign next_route[ch] = (next_cfg.pick == SEL_W'(ch));
    end

    // Decoded from the next capture so gain moves with active_cfg
    always_comb begin
        case ({next_cfg.bypass, next_cfg.gain_bits})
            4'b0000: next_gain = GAIN_UNITY;
            4'b0001: next_gain = 5'h02;
            4'b0010: next_gain = 5'h03;
            4'b0011: next_gain = 5'h04;
            4'b0100: next_gain = 5'h06;
            4'b0101: next_gain = 5'h08;
            4'b0110: next_gain = 5'h0c;
            4'b0111: next_gain = 5'h10;
            default: next_gain = GAIN_BYPASS;
        endcase
    end

    // Reset matches the cfg reset: input 0, gain of one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            route <= ONE_HOT_0;
            gain  <= GAIN_UNITY;
        end else begin
            route <= next_route;
            gain  <= next_gain;
        end
    end

    assign input_route = route;
    assign amp_gain    = gain;

    // ------------------------------------------------------------
    // Output code range
    // ------------------------------------------------------------
    logic              next_code_valid;
    logic [CODE_W-1:0] next_code_out;
    logic              full_span;

    // Gain of one behaves like bypass: the core only sees half scale
    assign full_span = (amp_gain != GAIN_BYPASS) && (amp_gain != GAIN_UNITY);

    // Clamping rather than wrapping keeps an overdriven input at
    // the rail code instead of flipping its sign
    always_comb begin
        next_code_valid = raw_valid;
        next_code_out   = code_out;
        if (raw_valid) begin
            if (!cfg.signed_fmt) begin
                if (raw_code < 14'sh0000) begin
                    next_code_out = '0;
                end else if ($unsigned(raw_code) > UNS_MAX) begin
                    next_code_out = UNS_MAX;
                end else begin
                    next_code_out = raw_code;
                end
            end else if (full_span) begin
                next_code_out = raw_code;
            end else if (raw_code > HALF_MAX) begin
                next_code_out = HALF_MAX;
            end else if (raw_code < HALF_MIN) begin
                next_code_out = HALF_MIN;
            end else begin
                next_code_out = raw_code;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            code_valid <= 1'b0;
            code_out   <= '0;
        end else begin
            code_valid <= next_code_valid;
            code_out   <= next_code_out;
        end
    end

    // ------------------------------------------------------------
    // Static power state
    // ------------------------------------------------------------
    apcf_pwr_type pwr;
    apcf_pwr_type next_pwr;
    logic         sleep_allowed;
    logic         next_static_sleep;

    // Economy mode may not sleep until it has acquired once
    assign sleep_allowed = !pin_cfg.economy || econ_acq_done;

    always_comb begin
        next_pwr = pwr;
        case (pwr)
            APCF_AWAKE: begin
                if (!cs_n_s && sleep_allowed) begin
                    if (!pd_n_s) begin
                        next_pwr = APCF_PD_SEEN;
                    end else if (!pin_cfg.economy) begin
                        next_pwr = APCF_ASLEEP;
                    end
                end
            end
            APCF_PD_SEEN: begin
                if (cs_n_s) begin
                    next_pwr = APCF_AWAKE;
                end else if (pd_n_s) begin
                    next_pwr = APCF_ASLEEP;
                end
            end
            APCF_ASLEEP: begin
                // Chip select high or a new acquisition wakes the core
                if (cs_n_s || acq_start) begin
                    next_pwr = APCF_AWAKE;
                end
            end
            default: next_pwr = APCF_AWAKE;
        endcase
    end

    assign next_static_sleep = (next_pwr == APCF_ASLEEP);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pwr          <= APCF_AWAKE;
            static_sleep <= 1'b0;
        end else begin
            pwr          <= next_pwr;
            static_sleep <= next_static_sleep;
        end
    end

endmodule : apcf_top

`default_nettype wire

// >>> hw/apcf_pkg.sv
// Package for the pin configuration and code format block.
// Assumes a single core clock domain; no register bus.
package apcf_pkg;

    // ------------------------------------------------------------
    // Sizes and code limits
    // ------------------------------------------------------------
    localparam int unsigned NUM_INPUTS = 8;
    localparam int unsigned SEL_W      = 3;
    localparam int unsigned CODE_W     = 14;
    localparam logic signed [CODE_W-1:0] FULL_MAX = 14'sh1fff;
    localparam logic signed [CODE_W-1:0] FULL_MIN = 14'sh2000;
    localparam logic signed [CODE_W-1:0] HALF_MAX = 14'sh0fff;
    localparam logic signed [CODE_W-1:0] HALF_MIN = 14'sh3000;
    localparam logic [CODE_W-1:0]        UNS_MAX  = 14'h1fff;
    localparam logic [SEL_W-1:0]         FIRST_INPUT = 3'h0;
    localparam logic [NUM_INPUTS-1:0]    ONE_HOT_0   = 8'h01;
    localparam logic [4:0]               GAIN_BYPASS = 5'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        APCF_AWAKE   = 3'b001,
        APCF_PD_SEEN = 3'b010,
        APCF_ASLEEP  = 3'b100
    } apcf_pwr_type;

    typedef struct packed {
        logic [SEL_W-1:0] pick;
        logic             bypass;
        logic [1:0]       gain_lo;
        logic [2:0]       gain_bits;
        logic             signed_fmt;
        logic             economy;
        logic             sweep;
    } apcf_cfg_type;

endpackage : apcf_pkg

// >>> tb/apcf_checker.sv
// Assertions on the strap decode, code limits and sleep ports.
// Assumes a bind onto apcf_top; single core_clk domain.
`timescale 1ns/1ps
`default_nettype none
module apcf_checker
    import apcf_pkg::*;
(
    // Clock and reset
    input wire logic                     core_clk,
    input wire logic                     rst,
    // Watched ports
    input wire logic                     acq_start,
    input wire logic                     raw_valid,
    input wire logic signed [CODE_W-1:0] raw_code,
    input wire logic                     chip_select_n,
    input wire logic [NUM_INPUTS-1:0]    input_route,
    input wire apcf_cfg_type             active_cfg,
    input wire logic [4:0]               amp_gain,
    input wire logic                     code_valid,
    input wire logic [CODE_W-1:0]        code_out,
    input wire logic                     static_sleep
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ----
    // Properties
    // ----
    route_onehot_a: assert property ($onehot(input_route))
        else $error("route not one-hot");
    route_pick_a: assert property (input_route == (8'h01 << active_cfg.pick))
        else $error("route differs from pick");
    bypass_gain_a: assert property (active_cfg.bypass |-> amp_gain == 5'h00)
        else $error("bypass gain not zero");
    gain_two_a: assert property (!active_cfg.bypass && active_cfg.gain_bits == 3'h1 |-> amp_gain == 5'h02)
        else $error("gain pattern 1 not two");
    unsigned_cap_a: assert property (code_valid && !active_cfg.signed_fmt |-> !code_out[13])
        else $error("unsigned code above 8191");
    half_span_a: assert property (code_valid && active_cfg.signed_fmt && amp_gain < 5'h02 |-> code_out[13] == code_out[12])
        else $error("half span exceeded");
    full_pass_a: assert property (raw_valid && active_cfg.signed_fmt && amp_gain > 5'h01 |=> code_valid && code_out == $past(raw_code))
        else $error("full span code altered");
    cfg_hold_a: assert property (!acq_start |=> $stable(active_cfg))
        else $error("config moved without acquisition");
    sleep_cause_a: assert property ($rose(static_sleep) |-> !$past(chip_select_n, 3))
        else $error("sleep without chip select low");
    cover property ($rose(static_sleep));
    cover property (code_valid && !active_cfg.signed_fmt);
    cover property (acq_start && active_cfg.sweep);
endmodule : apcf_checker

bind apcf_top apcf_checker i_apcf_checker (.core_clk, .rst, .acq_start, .raw_valid, .raw_code, .chip_select_n,
    .input_route, .active_cfg, .amp_gain, .code_valid, .code_out, .static_sleep);
`default_nettype wire

// >>> tb/apcf_host.sv
// Host model: drives strap pins, chip select and sleep request.
// Assumes tasks are called just after a core_clk edge.
`timescale 1ns/1ps
`default_nettype none
module apcf_host (
    // Clock
    input wire logic core_clk,
    // Straps and power pins
    output logic     input_pick_bit2,
    output logic     input_pick_bit1,
    output logic     input_pick_bit0,
    output logic     amp_gain_msb_or_bypass,
    output logic     amp_gain_msb_floating,
    output logic     amp_gain_bit1,
    output logic     amp_gain_bit0,
    output logic     format_strap_floating,
    output logic     economy_mode_sel,
    output logic     sweep_mode_sel,
    output logic     chip_select_n,
    output logic     sleep_request_n
);
    task set(input logic [2:0] ch, g, input logic bp, fmt, eco, sw);
        {input_pick_bit2, input_pick_bit1, input_pick_bit0} = ch;
        // Floating msb pin reads as the opposite of its last level
        amp_gain_msb_or_bypass = bp ? ~amp_gain_msb_or_bypass : g[2];
        {amp_gain_bit1, amp_gain_bit0} = g[1:0];
        amp_gain_msb_floating = bp;
        format_strap_floating = fmt;
        economy_mode_sel = eco;
        sweep_mode_sel = sw;
    endtask : set
    task sel(input logic v);
        chip_select_n = v;
    endtask : sel
    task nap();
        sleep_request_n = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 sleep_request_n = 1'b1;
    endtask : nap
    initial begin
        amp_gain_msb_or_bypass = 1'b0;
        chip_select_n = 1'b1;
        sleep_request_n = 1'b1;
        set(3'h0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    end
endmodule : apcf_host
`default_nettype wire

// >>> tb/apcf_top_tb.sv
// Bench for strap decode, code limits, sweep and static sleep.
// Assumes the host model owns the pins; bench drives conversions.
`timescale 1ns/1ps
`default_nettype none
module apcf_top_tb;
    import apcf_pkg::*;
    logic                     core_clk = 1'b0;
    logic                     rst = 1'b1;
    logic                     acq_start = 1'b0;
    logic                     raw_valid = 1'b0;
    logic signed [CODE_W-1:0] raw_code = 14'h0000;
    wire                      input_pick_bit2, input_pick_bit1, input_pick_bit0, amp_gain_msb_or_bypass;
    wire                      amp_gain_msb_floating, amp_gain_bit1, amp_gain_bit0, format_strap_floating;
    wire                      economy_mode_sel, sweep_mode_sel, chip_select_n, sleep_request_n;
    logic [NUM_INPUTS-1:0]    input_route;
    apcf_cfg_type             active_cfg;
    logic [4:0]               amp_gain;
    logic                     code_valid, static_sleep;
    logic [CODE_W-1:0]        code_out;
    logic [4:0]               gt [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10};
    int                       error_cnt = 0;
    int                       checks_done = 0;
    int                       i;

    apcf_host i_apcf_host (.core_clk, .input_pick_bit2, .input_pick_bit1, .input_pick_bit0,
        .amp_gain_msb_or_bypass, .amp_gain_msb_floating, .amp_gain_bit1, .amp_gain_bit0,
        .format_strap_floating, .economy_mode_sel, .sweep_mode_sel, .chip_select_n, .sleep_request_n);
    apcf_top i_apcf_top (.core_clk, .rst, .input_pick_bit2, .input_pick_bit1, .input_pick_bit0,
        .amp_gain_msb_or_bypass, .amp_gain_msb_floating, .amp_gain_bit1, .amp_gain_bit0,
        .format_strap_floating, .economy_mode_sel, .sweep_mode_sel, .chip_select_n, .sleep_request_n,
        .acq_start, .raw_valid, .raw_code, .input_route, .active_cfg, .amp_gain, .code_valid,
        .code_out, .static_sleep);

    initial forever #4 core_clk = ~core_clk;

    task chk(input logic [15:0] s, e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task tally_and_finish();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task acq();
        @(posedge core_clk) #1 acq_start = 1'b1;
        @(posedge core_clk) #1 acq_start = 1'b0;
        @(posedge core_clk) #1;
    endtask : acq
    // Straps need two sync stages before the acquisition takes them
    task cfg(input logic [2:0] ch, g, input logic bp, fmt, eco, sw);
        i_apcf_host.set(ch, g, bp, fmt, eco, sw);
        repeat (3) @(posedge core_clk);
        acq();
    endtask : cfg
    task conv(input logic [13:0] r, e);
        @(posedge core_clk) #1 raw_valid = 1'b1;
        raw_code = r;
        @(posedge core_clk) #1 raw_valid = 1'b0;
        raw_code = ~r;
        chk(code_valid, 1'b1);
        chk(code_out, e);
    endtask : conv
    task wait_sleep(input logic e);
        repeat (6) @(posedge core_clk);
        #1 chk(static_sleep, e);
    endtask : wait_sleep

    initial begin
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        chk(input_route, 8'h01);
        for (i = 0; i < 8; i++) begin
            cfg(i[2:0], i[2:0], 1'b0, 1'b1, 1'b0, 1'b0);
            chk(input_route, 8'h01 << i);
            chk(amp_gain, gt[i]);
        end
        cfg(3'h4, 3'h5, 1'b1, 1'b1, 1'b0, 1'b0);
        chk(amp_gain, 5'h00);
        chk(active_cfg.signed_fmt, 1'b1);
        conv(14'h1fff, 14'h0fff);
        conv(14'h2000, 14'h3000);
        cfg(3'h1, 3'h1, 1'b0, 1'b1, 1'b0, 1'b0);
        conv(14'h2000, 14'h2000);
        conv(14'h1fff, 14'h1fff);
        cfg(3'h5, 3'h7, 1'b0, 1'b0, 1'b0, 1'b0);
        chk(active_cfg.signed_fmt, 1'b0);
        conv(14'h3ffb, 14'h0000);
        conv(14'h1fff, 14'h1fff);
        cfg(3'h6, 3'h1, 1'b0, 1'b1, 1'b0, 1'b1);
        chk(input_route, 8'h01);
        for (i = 1; i < 9; i++) begin
            acq();
            chk(input_route, 8'h01 << (i % 8));
        end
        cfg(3'h2, 3'h3, 1'b0, 1'b0, 1'b0, 1'b0);
        i_apcf_host.set(3'h7, 3'h3, 1'b0, 1'b0, 1'b1, 1'b0);
        repeat (4) @(posedge core_clk);
        #1 chk(input_route, 8'h04);
        // Normal mode: chip select low alone sleeps
        i_apcf_host.set(3'h2, 3'h3, 1'b0, 1'b0, 1'b0, 1'b0);
        i_apcf_host.sel(1'b0);
        wait_sleep(1'b1);
        i_apcf_host.sel(1'b1);
        wait_sleep(1'b0);
        // Economy before any economy acquisition: no sleep, even with a pulse
        i_apcf_host.set(3'h2, 3'h3, 1'b0, 1'b0, 1'b1, 1'b0);
        i_apcf_host.sel(1'b0);
        wait_sleep(1'b0);
        i_apcf_host.nap();
        wait_sleep(1'b0);
        i_apcf_host.sel(1'b1);
        acq();
        chk(active_cfg.economy, 1'b1);
        i_apcf_host.sel(1'b0);
        wait_sleep(1'b0);
        i_apcf_host.nap();
        wait_sleep(1'b1);
        acq();
        chk(static_sleep, 1'b0);
        tally_and_finish();
    end

    initial begin
        #50us;
        error_cnt++;
        tally_and_finish();
    end
endmodule : apcf_top_tb
`default_nettype wire
